// >>> inc/gpt_defines.vh
// Register map, field layout and timing constants of the pulse totalizer.
`ifndef GPT_DEFINES_VH
`define GPT_DEFINES_VH

// ****************************************
// Sizes
// ****************************************
`define GPT_CH_N 4
`define GPT_CNT_W 32
`define GPT_IN_N 6
`define GPT_ADDR_W 8
`define GPT_IN_GHI 4
`define GPT_IN_GLO 5

// ****************************************
// Rates
// ****************************************
`define GPT_CLK_HZ 20000000
`define GPT_FAST_MAX_HZ 10000000
`define GPT_NORM_MAX_HZ 100000

// ****************************************
// Address pages and registers
// ****************************************
`define GPT_PAGE_HI 7
`define GPT_PAGE_LO 4
`define GPT_PAGE_CSR 4'h0
`define GPT_PAGE_CNT 4'h1
`define GPT_PAGE_RC 4'h2
`define GPT_PAGE_TGT 4'h3
`define GPT_CSR_CTRL 2'h0
`define GPT_CSR_STAT 2'h1

// ****************************************
// Control fields
// ****************************************
`define GPT_CTRL_RUN 0
`define GPT_CTRL_EDGE 4
`define GPT_CTRL_SCAN 8
`define GPT_CTRL_AEN 12
`define GPT_CTRL_GHI 16
`define GPT_CTRL_GLO 17
`define GPT_CTRL_MASK 32'h0003_ffff
`define GPT_CTRL_RST 32'h0000_0000

// ****************************************
// Status fields
// ****************************************
`define GPT_STAT_ALM 0
`define GPT_STAT_LVL 4
`define GPT_STAT_GATE 10

// ****************************************
// Bus answers and reset values
// ****************************************
`define GPT_RESP_OKAY 2'h0
`define GPT_RESP_SLVERR 2'h2
`define GPT_ZERO32 32'h0000_0000
`define GPT_TGT_RST 32'hffff_ffff

`endif

// >>> core/gpt_sync.v
// Two-stage synchroniser with edge detection for the pulse and gate pins.
`timescale 1ns/1ps
module gpt_sync #(
	parameter W = 6
) (
	mclk,
	reset,
	pin_in,
	level,
	rise,
	fall
);
	input wire mclk;
	input wire reset;
	input wire [W-1:0] pin_in;
	output wire [W-1:0] level;
	output wire [W-1:0] rise;
	output wire [W-1:0] fall;

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	reg [W-1:0] prev_q;

	// ****************************************
	// Capture and history
	// ****************************************
	// First stage is read only by the second stage
	always @(posedge mclk) begin
		if (reset) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
			prev_q <= {W{1'b0}};
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges come from the settled stages only
	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule // gpt_sync

// >>> core/gpt_chan.v
// One 32-bit totalizer channel with loss-free clear.
`timescale 1ns/1ps
`include "gpt_defines.vh"
module gpt_chan (
	mclk,
	reset,
	inc,
	clear,
	count
);
	input wire mclk;
	input wire reset;
	input wire inc;
	input wire clear;
	output wire [`GPT_CNT_W-1:0] count;

	reg [`GPT_CNT_W-1:0] count_q;
	reg [`GPT_CNT_W-1:0] count_d;

	// ****************************************
	// Count update
	// ****************************************
	// Edge landing with the clear is kept as the first new count
	always @* begin
		count_d = count_q;
		if (clear) begin
			count_d = inc ? {{(`GPT_CNT_W-1){1'b0}}, 1'b1} : {`GPT_CNT_W{1'b0}};
		end else if (inc) begin
			count_d = count_q + {{(`GPT_CNT_W-1){1'b0}}, 1'b1}; // Wraps at all ones
		end
	end

	always @(posedge mclk) begin
		if (reset) begin
			count_q <= `GPT_ZERO32;
		end else begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
endmodule // gpt_chan

// >>> core/gpt_top.v
// Four-channel gated pulse totalizer with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "gpt_defines.vh"
// Operation
// - Four independent unsigned 32-bit count channels
// - Channels 0,1 count pulses up to 10 MHz
// - Channels 2,3 count pulses up to 100 kHz
// - Per-channel edge select: rising or falling
// - Both gates used: high gate high, low gate low
// - Only high gate used: count while high
// - Only low gate used: count while low
// - No gate used: count continuously
// - Read-and-clear restarts at zero, keeps coincident edge
// - Plain read leaves count untouched
// - Maximum count wraps to zero and continues
// - Unscanned channel started, stopped, holds count
// - Scanned counts handed to scanner each pass
// - Unscanned channel alarms when count hits target
module gpt_top (
	mclk,
	reset,
	pulse_in,
	gate_hi,
	gate_lo_n,
	scan_req,
	scan_done,
	scan_counts,
	alarm,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready
);
	input wire mclk;
	input wire reset;
	input wire [`GPT_CH_N-1:0] pulse_in;
	input wire gate_hi;
	input wire gate_lo_n;
	input wire scan_req;
	output reg scan_done;
	output reg [`GPT_CH_N*`GPT_CNT_W-1:0] scan_counts;
	output reg [`GPT_CH_N-1:0] alarm;
	input wire [`GPT_ADDR_W-1:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output reg s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output reg s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [`GPT_ADDR_W-1:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output reg s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;

	// ****************************************
	// Helpers
	// ****************************************
	// Merge write data into a register under the byte strobes
	function [31:0] strb_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] strb;
		integer b;
		begin
			strb_merge = old_v;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b]) begin
					strb_merge[b*8 +: 8] = new_v[b*8 +: 8];
				end
			end
		end
	endfunction

	// Does the address fall on a given page
	function page_hit;
		input [`GPT_ADDR_W-1:0] addr;
		input [3:0] page;
		begin
			page_hit = (addr[`GPT_PAGE_HI:`GPT_PAGE_LO] == page);
		end
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	wire [`GPT_IN_N-1:0] in_lvl;
	wire [`GPT_IN_N-1:0] in_rise;
	wire [`GPT_IN_N-1:0] in_fall;
	wire [`GPT_CNT_W-1:0] count [0:`GPT_CH_N-1];
	reg [`GPT_CH_N-1:0] inc;
	reg [`GPT_CH_N-1:0] rc_clr;
	reg [31:0] ctrl_q;
	reg [`GPT_CH_N-1:0] alm_q;
	reg [`GPT_CH_N-1:0] eq_q;
	reg [`GPT_CNT_W-1:0] tgt_q [0:`GPT_CH_N-1];
	reg [`GPT_ADDR_W-1:0] aw_addr_q;
	reg aw_full_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_full_q;
	reg [31:0] rd_mux;
	reg rd_ok;
	wire gate_ok;
	wire wr_fire;
	wire rd_fire;
	wire wr_ok;
	integer i, j, k, m;

	// ****************************************
	// Input conditioning
	// ****************************************
	// Bits 3:0 pulses, 4 high gate, 5 low gate; all cross from pins
	gpt_sync #(
		.W(`GPT_IN_N)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.pin_in({gate_lo_n, gate_hi, pulse_in}),
		.level(in_lvl),
		.rise(in_rise),
		.fall(in_fall)
	);

	// Gate use bits stand in for "terminal driven", which logic cannot sense
	assign gate_ok = (~ctrl_q[`GPT_CTRL_GHI] | in_lvl[`GPT_IN_GHI])
		& (~ctrl_q[`GPT_CTRL_GLO] | ~in_lvl[`GPT_IN_GLO]);

	// ****************************************
	// Channel qualification
	// ****************************************
	// Scanned channels always run; others follow the run bit
	always @* begin
		for (i = 0; i < `GPT_CH_N; i = i + 1) begin
			inc[i] = (ctrl_q[`GPT_CTRL_EDGE + i] ? in_fall[i] : in_rise[i])
				& gate_ok
				& (ctrl_q[`GPT_CTRL_SCAN + i] | ctrl_q[`GPT_CTRL_RUN + i]);
		end
	end

	// Fast pair and normal pair share one design; at 20 MHz sampling the
	// fast pair needs both pulse phases of at least one clock period
	genvar g;
	generate
		for (g = 0; g < `GPT_CH_N; g = g + 1) begin : g_chan
			gpt_chan u_chan (
				.mclk(mclk),
				.reset(reset),
				.inc(inc[g]),
				.clear(rc_clr[g]),
				.count(count[g])
			);
		end
	endgenerate

	// ****************************************
	// Write channel
	// ****************************************
	// Address and data are taken in either order, one write at a time
	assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wr_ok = page_hit(aw_addr_q, `GPT_PAGE_TGT)
		| (page_hit(aw_addr_q, `GPT_PAGE_CSR) & ~aw_addr_q[3]);

	always @(posedge mclk) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `GPT_RESP_OKAY;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= {`GPT_ADDR_W{1'b0}};
			w_data_q <= `GPT_ZERO32;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q <= s_axi_awaddr;
				aw_full_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				w_full_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
			end
			// Ready rises only once the response is gone
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ****************************************
	// Control and targets
	// ****************************************
	always @(posedge mclk) begin
		if (reset) begin
			ctrl_q <= `GPT_CTRL_RST;
			for (j = 0; j < `GPT_CH_N; j = j + 1) begin
				tgt_q[j] <= `GPT_TGT_RST;
			end
		end else if (wr_fire) begin
			if (page_hit(aw_addr_q, `GPT_PAGE_CSR) && aw_addr_q[3:2] == `GPT_CSR_CTRL) begin
				ctrl_q <= strb_merge(ctrl_q, w_data_q, w_strb_q) & `GPT_CTRL_MASK;
			end
			if (page_hit(aw_addr_q, `GPT_PAGE_TGT)) begin
				tgt_q[aw_addr_q[3:2]] <= strb_merge(tgt_q[aw_addr_q[3:2]], w_data_q, w_strb_q);
			end
		end
	end

	// ****************************************
	// Alarm
	// ****************************************
	// Fires on arrival at the target, not while parked on it; sticky bit
	// is write-one-to-clear and a new alarm wins over the clear
	always @(posedge mclk) begin
		if (reset) begin
			alm_q <= {`GPT_CH_N{1'b0}};
			eq_q <= {`GPT_CH_N{1'b0}};
			alarm <= {`GPT_CH_N{1'b0}};
		end else begin
			for (k = 0; k < `GPT_CH_N; k = k + 1) begin
				eq_q[k] <= (count[k] == tgt_q[k]);
				alarm[k] <= (count[k] == tgt_q[k]) & ~eq_q[k]
					& ctrl_q[`GPT_CTRL_AEN + k] & ~ctrl_q[`GPT_CTRL_SCAN + k];
				if (wr_fire && page_hit(aw_addr_q, `GPT_PAGE_CSR)
					&& aw_addr_q[3:2] == `GPT_CSR_STAT && w_strb_q[0] && w_data_q[k]) begin
					alm_q[k] <= 1'b0;
				end
				if (alarm[k]) begin
					alm_q[k] <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Scan hand-off
	// ****************************************
	// Only scanned channels are refreshed; others keep their last snapshot
	always @(posedge mclk) begin
		if (reset) begin
			scan_done <= 1'b0;
			scan_counts <= {(`GPT_CH_N*`GPT_CNT_W){1'b0}};
		end else begin
			scan_done <= scan_req;
			for (m = 0; m < `GPT_CH_N; m = m + 1) begin
				if (scan_req && ctrl_q[`GPT_CTRL_SCAN + m]) begin
					scan_counts[m*`GPT_CNT_W +: `GPT_CNT_W] <= count[m];
				end
			end
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	assign rd_fire = s_axi_arvalid & s_axi_arready;

	// Read data selection; unmapped answers zero with an error
	always @* begin
		rd_mux = `GPT_ZERO32;
		rd_ok = 1'b1;
		rc_clr = {`GPT_CH_N{1'b0}};
		case (s_axi_araddr[`GPT_PAGE_HI:`GPT_PAGE_LO])
			`GPT_PAGE_CSR: begin
				if (s_axi_araddr[3:2] == `GPT_CSR_CTRL) begin
					rd_mux = ctrl_q;
				end else if (s_axi_araddr[3:2] == `GPT_CSR_STAT) begin
					rd_mux[`GPT_STAT_ALM +: `GPT_CH_N] = alm_q;
					rd_mux[`GPT_STAT_LVL +: `GPT_IN_N] = in_lvl;
					rd_mux[`GPT_STAT_GATE] = gate_ok;
				end else begin
					rd_ok = 1'b0;
				end
			end
			`GPT_PAGE_CNT: begin
				rd_mux = count[s_axi_araddr[3:2]]; // No side effect
			end
			`GPT_PAGE_RC: begin
				rd_mux = count[s_axi_araddr[3:2]];
				rc_clr[s_axi_araddr[3:2]] = rd_fire;
			end
			`GPT_PAGE_TGT: begin
				rd_mux = tgt_q[s_axi_araddr[3:2]];
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// Data is captured on the address edge, the same edge that clears
	always @(posedge mclk) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `GPT_ZERO32;
			s_axi_rresp <= `GPT_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `GPT_RESP_OKAY : `GPT_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // gpt_top

// >>> bench/gpt_tb_sva.sv
// Checker of scan, alarm and bus timing at the totalizer's ports.
`timescale 1ns/1ps
module gpt_chk (
	input wire mclk,
	input wire reset,
	input wire scan_req,
	input wire scan_done,
	input wire [127:0] scan_counts,
	input wire [3:0] alarm,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	property p_sdone; scan_req |=> scan_done; endproperty
	a_sdone: assert property (p_sdone) else $error("scan_done missing");
	property p_sonly; !scan_req |=> !scan_done; endproperty
	a_sonly: assert property (p_sonly) else $error("scan_done unasked");
	// Counts move only on a pass, so the scanner sees a steady snapshot
	property p_shold; !scan_req |=> $stable(scan_counts); endproperty
	a_shold: assert property (p_shold) else $error("scan_counts moved");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	property p_rst; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rst: assert property (p_rst) else $error("read data dropped");
	property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rend: assert property (p_rend) else $error("read answer repeated");
	// Both halves are staged first, so the answer stands one cycle later
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	property p_bst; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bst: assert property (p_bst) else $error("write answer dropped");
	// Equality is edge detected, so an alarm never lasts two cycles
	property p_alm; |alarm |=> (alarm & $past(alarm)) == 4'h0; endproperty
	a_alm: assert property (p_alm) else $error("alarm held");
	c_scan: cover property (scan_done);
	c_alm: cover property (alarm[2]);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // gpt_chk

// >>> bench/gpt_src.sv
// Pulse source model standing at the totalizer's pulse pins.
`timescale 1ns/1ps
module gpt_src (
	input wire logic mclk,
	input wire logic [3:0] inv,
	output logic [3:0] pulse
);
	// ****
	// Source
	// ****
	logic [3:0] p_q = 4'h0;
	// Inversion mask gives the bench single level steps
	assign pulse = p_q ^ inv;
	// Phases of h cycles each; h=1 is the fastest legal rate
	task send(input logic [3:0] m, input int n, input int h);
		repeat (n) begin
			p_q <= m;
			repeat (h) @(posedge mclk);
			p_q <= 4'h0;
			repeat (h) @(posedge mclk);
		end
	endtask
endmodule // gpt_src

// >>> bench/gpt_tb.sv
// Self-checking bench of the four-channel pulse totalizer.
`timescale 1ns/1ps
module testbench;
	logic mclk = 0, reset = 1, gate_hi = 0, gate_lo_n = 1, scan_req = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, d;
	logic [3:0] s_axi_wstrb = 4'hf, inv = 4'h0;
	logic [1:0] r;
	wire [3:0] pulse_in, alarm;
	wire scan_done, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [127:0] scan_counts;
	int miscompares = 0, n_tests = 0, cyc = 0, n_alm = 0;
	// ****
	// Harness
	// ****
	gpt_top i_gpt_top (.mclk, .reset, .pulse_in, .gate_hi, .gate_lo_n, .scan_req, .scan_done,
		.scan_counts, .alarm, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	gpt_src i_gpt_src (.mclk, .inv, .pulse(pulse_in));
	initial forever #25 mclk = ~mclk;
	// Hang guard, far above the few thousand cycles needed
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (alarm[2] === 1'b1) n_alm++;
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end
	task close_out;
		$display("Checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		fork
			begin
				do @(posedge mclk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge mclk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		// Ready held back so the answer must stand until it is taken
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b1;
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		@(posedge mclk);
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk("rdata", e, d);
	endtask
	// Pulses, then room for the synchroniser to settle
	task burst(input logic [3:0] m, input int n, input int h);
		i_gpt_src.send(m, n, h);
		repeat (6) @(posedge mclk);
	endtask
	// ****
	// Scenarios
	// ****
	task t_reset;
		rc(8'h00, 32'h0000_0000);
		rc(8'h30, 32'hffff_ffff);
		rc(8'h10, 32'h0000_0000);
		rc(8'h40, 32'h0000_0000);
		chk("rresp", 32'h0000_0002, 32'(r));
		wr(8'h10, 32'h0000_0001);
		chk("bresp", 32'h0000_0002, 32'(r));
	endtask
	task t_free;
		wr(8'h00, 32'h0000_000f);
		burst(4'h3, 5, 1);
		burst(4'hc, 5, 100);
		for (int i = 0; i < 8; i++) rc(8'h10 + 8'(4 * (i % 4)), 32'h0000_0005);
	endtask
	task t_clr;
		for (int i = 0; i < 4; i++) begin
			rc(8'h20 + 8'(4 * i), 32'h0000_0005);
			rc(8'h10 + 8'(4 * i), 32'h0000_0000);
		end
	endtask
	task t_edge;
		wr(8'h00, 32'h0000_0023);
		inv <= 4'h3;
		repeat (6) @(posedge mclk);
		rc(8'h10, 32'h0000_0001);
		rc(8'h14, 32'h0000_0000);
		inv <= 4'h0;
		repeat (6) @(posedge mclk);
		rc(8'h14, 32'h0000_0001);
	endtask
	task t_gate;
		logic [4:0] tab [7];
		// Fields: high used, low used, gate_hi, gate_lo_n, counts
		tab = '{5'b10000, 5'b10111, 5'b01110, 5'b01001, 5'b11110, 5'b11101, 5'b00011};
		rd(8'h20);
		for (int k = 0; k < 7; k++) begin
			wr(8'h00, {14'h0000, tab[k][3], tab[k][4], 16'h0001});
			gate_hi <= tab[k][2];
			gate_lo_n <= tab[k][1];
			repeat (4) @(posedge mclk);
			burst(4'h1, 3, 2);
			rc(8'h20, tab[k][0] ? 32'h0000_0003 : 32'h0000_0000);
		end
	endtask
	task t_run;
		wr(8'h00, 32'h0000_0001);
		burst(4'h1, 2, 2);
		rc(8'h10, 32'h0000_0002);
		wr(8'h00, 32'h0000_0000);
		burst(4'h1, 3, 2);
		rc(8'h10, 32'h0000_0002);
		wr(8'h00, 32'h0000_0001);
		burst(4'h1, 1, 2);
		rc(8'h10, 32'h0000_0003);
	endtask
	task t_scan;
		wr(8'h00, 32'h0000_0800);
		burst(4'h8, 4, 100);
		scan_req <= 1'b1;
		@(posedge mclk);
		scan_req <= 1'b0;
		@(posedge mclk);
		chk("scan_done", 32'h0000_0001, 32'(scan_done));
		chk("scan_counts", 32'h0000_0004, scan_counts[127:96]);
	endtask
	task t_alarm;
		wr(8'h38, 32'h0000_0002);
		wr(8'h00, 32'h0000_4004);
		n_alm = 0;
		burst(4'h4, 2, 100);
		chk("alarm", 32'h0000_0001, 32'(n_alm));
		rd(8'h04);
		chk("sticky", 32'h0000_0004, d & 32'h0000_000f);
		wr(8'h04, 32'h0000_0004);
		rd(8'h04);
		chk("sticky", 32'h0000_0000, d & 32'h0000_000f);
		// Same channel scanned: reaching the target must stay silent
		wr(8'h38, 32'h0000_0004);
		wr(8'h00, 32'h0000_4400);
		n_alm = 0;
		burst(4'h4, 2, 100);
		chk("alarm_scan", 32'h0000_0000, 32'(n_alm));
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		t_reset;
		t_free;
		t_clr;
		t_edge;
		t_gate;
		t_run;
		t_scan;
		t_alarm;
		close_out;
	end
endmodule // testbench
bind gpt_top gpt_chk i_gpt_chk (.mclk, .reset, .scan_req, .scan_done, .scan_counts, .alarm,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
